// >>> hdl/mcsr_pkg.sv
// constants and carrier types of the monitor configuration and status register bank
package mcsr_pkg;
  // ===========================================
  // register offsets
  localparam logic [7:0] ADDR_PRIMARY_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_MONITOR_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h7B;
  localparam logic [7:0] ADDR_FAN6_HIGH = 8'hA5;
  localparam logic [7:0] ADDR_FAN7_LOW = 8'hA6;
  localparam logic [7:0] ADDR_FAN7_HIGH = 8'hA7;
  localparam logic [7:0] ADDR_FAN8_LOW = 8'hA8;
  localparam logic [7:0] ADDR_FAN8_HIGH = 8'hA9;
  localparam logic [7:0] ADDR_DRIVE1 = 8'hAA;
  localparam logic [7:0] ADDR_DRIVE4 = 8'hAD;
  localparam logic [7:0] ADDR_OVERTEMP1 = 8'hAE;
  localparam logic [7:0] ADDR_OVERTEMP2 = 8'hAF;
  localparam logic [7:0] ADDR_THERMAL_A_HOST = 8'hB8;
  localparam logic [7:0] ADDR_THERMAL_B_HOST = 8'hB9;
  localparam logic [7:0] ADDR_THERMAL_C_HOST = 8'hBA;
  localparam logic [7:0] ADDR_VOLTAGE_A_HOST = 8'hBB;
  localparam logic [7:0] ADDR_VOLTAGE_B_HOST = 8'hBC;
  localparam logic [7:0] ADDR_FAN_HOST = 8'hBD;
  localparam logic [7:0] ADDR_DIGITAL_HOST = 8'hBE;
  localparam logic [7:0] ADDR_GENERAL_PIN_HOST = 8'hBF;
  localparam logic [7:0] ADDR_THERMAL_A_MGMT = 8'hC0;
  localparam logic [7:0] ADDR_THERMAL_B_MGMT = 8'hC1;
  localparam logic [7:0] ADDR_VOLTAGE_A_MGMT = 8'hC3;
  localparam logic [7:0] ADDR_VOLTAGE_B_MGMT = 8'hC4;
  localparam logic [7:0] ADDR_FAN_MGMT = 8'hC5;
  localparam logic [7:0] ADDR_DIGITAL_MGMT = 8'hC6;
  // ===========================================
  // reset values and key
  localparam logic [7:0] RESET_PRIMARY_CONFIG = 8'h20;
  localparam logic [7:0] RESET_MONITOR_CONTROL = 8'h81;
  localparam logic [7:0] RESET_SPEED = 8'hFF;
  localparam logic [7:0] RESET_DRIVE = 8'h00;
  localparam logic [7:0] RESET_DRIVE3 = 8'hC0;
  localparam logic [7:0] UNLOCK_KEY = 8'h6D;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  // writable bits of the second configuration register (lock and ready excluded)
  localparam logic [7:0] MONITOR_CONTROL_WMASK = 8'h3F;
  // ===========================================
  // field positions
  localparam int BLOCK_LEN_MSB = 5;
  localparam int TABLE_SEL_BIT = 6;
  localparam int SOFT_RESTORE_BIT = 7;
  localparam int MONITOR_EN_BIT = 0;
  localparam int ALERT_MODE_BIT = 3;
  localparam int SKIP_SPINUP_BIT = 4;
  localparam int SETUP_DONE_BIT = 5;
  localparam int LOCK_BIT = 6;
  localparam int READY_BIT = 7;
  localparam int NUM_DRIVES = 4;
  // ===========================================
  // carriers
  typedef struct packed {
    logic [7:0] thermal_a;
    logic [7:0] thermal_b;
    logic [7:0] thermal_c;
    logic [7:0] voltage_a;
    logic [7:0] voltage_b;
    logic [7:0] fan;
    logic [7:0] digital;
  } mcsr_flags_type;

  typedef struct packed {
    logic [7:0] fan6_high;
    logic [7:0] fan7_low;
    logic [7:0] fan7_high;
    logic [7:0] fan8_low;
    logic [7:0] fan8_high;
    logic [7:0] overtemp1;
    logic [7:0] overtemp2;
  } mcsr_meas_type;

  typedef struct packed {
    logic [5:0] block_read_len;
    logic table_select;
    logic monitor_enable;
    logic alert_comparator;
    logic skip_fast_spinup;
    logic setup_complete;
    logic locked;
  } mcsr_ctrl_type;
endpackage

// >>> hdl/mcsr_regs.sv
// configuration and status register bank of a hardware monitor with fan control
// Summary of operation
// - primary config bits 5:0 give block read length, reset 0x20
// - primary config bit 6 selects regulator code table, 0 older default
// - writing bit 7 restores lockable registers to defaults, then self-clears
// - soft restore only acts after key 0x6D written to register 0x7B
// - control bit 0 enables measurements, default 1
// - control bit 3 picks comparator alert when 1, latched alert when 0
// - control bit 4 skips quick spin-up, fans use startup timeout instead
// - monitoring starts only after control bit 5 written 1, default 0
// - control bit 6 writable once; then lockable registers ignore writes
// - control bit 7 read-only, set once device is ready
// - primary config powers up 0x20, lockable, restored by soft restore
// - control register powers up 0x81, lockable, restored by soft restore
`timescale 1ns/1ps
module mcsr_regs #(
  parameter int FLAG_WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port from the serial interface engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // measurement and event side
  input wire mcsr_pkg::mcsr_meas_type meas,
  input wire mcsr_pkg::mcsr_flags_type flag_set,
  input wire logic general_pin_set_host,
  input wire logic [7:0] general_pin_in,
  input wire logic power_good,
  // control outputs
  output mcsr_pkg::mcsr_ctrl_type ctrl,
  output logic monitoring_active,
  output logic [mcsr_pkg::NUM_DRIVES*8-1:0] fan_drive_duty,
  output logic soft_restore_pulse
);
  import mcsr_pkg::*;
  // the ready bit is shown from its own flop, so the stored copy keeps it zero
  localparam logic [7:0] STORED_CONTROL_RESET = RESET_MONITOR_CONTROL & ~(8'h01 << READY_BIT);

  // the flag carriers are byte lanes; other widths would break the read mux
  if (FLAG_WIDTH != 8) begin : g_width_check
    $error("flag width must be 8");
  end

  // ===========================================
  // state
  logic [7:0] primary_config;
  logic [7:0] monitor_control_config;
  logic [7:0] unlock_key;
  logic [7:0] fan_drive [NUM_DRIVES];
  mcsr_flags_type flags_host;
  mcsr_flags_type flags_mgmt;
  logic [7:0] general_pin_flags_host;
  logic ready_q;
  logic restore;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // duty registers sit at consecutive offsets
  function automatic logic drive_hit(input logic [7:0] a);
    return a >= ADDR_DRIVE1 && a <= ADDR_DRIVE4;
  endfunction

  function automatic logic [1:0] drive_index(input logic [7:0] a);
    return 2'(a - ADDR_DRIVE1);
  endfunction

  // ===========================================
  // soft restore: key must stand before the reset bit is written
  assign restore = reg_wr && hit(reg_addr, ADDR_PRIMARY_CONFIG) &&
                   reg_wdata[SOFT_RESTORE_BIT] && !monitor_control_config[LOCK_BIT] &&
                   (unlock_key == UNLOCK_KEY);
  assign soft_restore_pulse = restore;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || restore) begin
      unlock_key <= RESET_ZERO;
    end else if (reg_wr && hit(reg_addr, ADDR_UNLOCK_KEY)) begin
      unlock_key <= reg_wdata;
    end
  end

  // ===========================================
  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      primary_config <= RESET_PRIMARY_CONFIG;
    end else if (restore) begin
      primary_config <= RESET_PRIMARY_CONFIG;
    end else if (reg_wr && hit(reg_addr, ADDR_PRIMARY_CONFIG) &&
                 !monitor_control_config[LOCK_BIT]) begin
      // reset bit never stored, so it reads back as zero
      primary_config <= {1'b0, reg_wdata[6:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      monitor_control_config <= STORED_CONTROL_RESET;
    end else if (restore) begin
      monitor_control_config <= STORED_CONTROL_RESET;
    end else if (reg_wr && hit(reg_addr, ADDR_MONITOR_CONTROL) &&
                 !monitor_control_config[LOCK_BIT]) begin
      monitor_control_config <= {1'b0, reg_wdata[LOCK_BIT],
                                 reg_wdata[5:0] & MONITOR_CONTROL_WMASK[5:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= power_good;
    end
  end

  // ===========================================
  // fan drive duty registers, not lockable and not restored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DRIVES; i++) begin
        fan_drive[i] <= (i == 2) ? RESET_DRIVE3 : RESET_DRIVE;
      end
    end else if (reg_wr && drive_hit(reg_addr)) begin
      fan_drive[drive_index(reg_addr)] <= reg_wdata;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_DRIVES; i++) begin
      fan_drive_duty[i*8 +: 8] = fan_drive[i];
    end
  end

  // ===========================================
  // status flags, sticky, two copies; set wins over read clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n || restore) begin
      flags_host <= '0;
      flags_mgmt <= '0;
    end else begin
      flags_host <= flags_host | flag_set;
      flags_mgmt <= flags_mgmt | flag_set;
      if (reg_rd) begin
        if (hit(reg_addr, ADDR_THERMAL_A_HOST)) begin
          flags_host.thermal_a <= flag_set.thermal_a;
        end else if (hit(reg_addr, ADDR_THERMAL_B_HOST)) begin
          flags_host.thermal_b <= flag_set.thermal_b;
        end else if (hit(reg_addr, ADDR_THERMAL_C_HOST)) begin
          flags_host.thermal_c <= flag_set.thermal_c;
        end else if (hit(reg_addr, ADDR_VOLTAGE_A_HOST)) begin
          flags_host.voltage_a <= flag_set.voltage_a;
        end else if (hit(reg_addr, ADDR_VOLTAGE_B_HOST)) begin
          flags_host.voltage_b <= flag_set.voltage_b;
        end else if (hit(reg_addr, ADDR_FAN_HOST)) begin
          flags_host.fan <= flag_set.fan;
        end else if (hit(reg_addr, ADDR_DIGITAL_HOST)) begin
          flags_host.digital <= flag_set.digital;
        end else if (hit(reg_addr, ADDR_THERMAL_A_MGMT)) begin
          flags_mgmt.thermal_a <= flag_set.thermal_a;
        end else if (hit(reg_addr, ADDR_THERMAL_B_MGMT)) begin
          flags_mgmt.thermal_b <= flag_set.thermal_b;
        end else if (hit(reg_addr, ADDR_VOLTAGE_A_MGMT)) begin
          flags_mgmt.voltage_a <= flag_set.voltage_a;
        end else if (hit(reg_addr, ADDR_VOLTAGE_B_MGMT)) begin
          flags_mgmt.voltage_b <= flag_set.voltage_b;
        end else if (hit(reg_addr, ADDR_FAN_MGMT)) begin
          flags_mgmt.fan <= flag_set.fan;
        end else if (hit(reg_addr, ADDR_DIGITAL_MGMT)) begin
          flags_mgmt.digital <= flag_set.digital;
        end
      end
    end
  end

  // general pin status: captured on request, host may overwrite
  always_ff @(posedge ref_clk) begin
    if (!rst_n || restore) begin
      general_pin_flags_host <= RESET_ZERO;
    end else if (general_pin_set_host) begin
      general_pin_flags_host <= general_pin_in;
    end else if (reg_wr && hit(reg_addr, ADDR_GENERAL_PIN_HOST)) begin
      general_pin_flags_host <= reg_wdata;
    end
  end

  // ===========================================
  // read mux
  always_comb begin
    if (hit(reg_addr, ADDR_PRIMARY_CONFIG)) begin
      next_rdata = primary_config;
    end else if (hit(reg_addr, ADDR_MONITOR_CONTROL)) begin
      next_rdata = {ready_q, monitor_control_config[6:0]};
    end else if (hit(reg_addr, ADDR_UNLOCK_KEY)) begin
      next_rdata = unlock_key;
    end else if (hit(reg_addr, ADDR_FAN6_HIGH)) begin
      next_rdata = meas.fan6_high;
    end else if (hit(reg_addr, ADDR_FAN7_LOW)) begin
      next_rdata = meas.fan7_low;
    end else if (hit(reg_addr, ADDR_FAN7_HIGH)) begin
      next_rdata = meas.fan7_high;
    end else if (hit(reg_addr, ADDR_FAN8_LOW)) begin
      next_rdata = meas.fan8_low;
    end else if (hit(reg_addr, ADDR_FAN8_HIGH)) begin
      next_rdata = meas.fan8_high;
    end else if (drive_hit(reg_addr)) begin
      next_rdata = fan_drive[drive_index(reg_addr)];
    end else if (hit(reg_addr, ADDR_OVERTEMP1)) begin
      next_rdata = meas.overtemp1;
    end else if (hit(reg_addr, ADDR_OVERTEMP2)) begin
      next_rdata = meas.overtemp2;
    end else if (hit(reg_addr, ADDR_THERMAL_A_HOST)) begin
      next_rdata = flags_host.thermal_a;
    end else if (hit(reg_addr, ADDR_THERMAL_B_HOST)) begin
      next_rdata = flags_host.thermal_b;
    end else if (hit(reg_addr, ADDR_THERMAL_C_HOST)) begin
      next_rdata = flags_host.thermal_c;
    end else if (hit(reg_addr, ADDR_VOLTAGE_A_HOST)) begin
      next_rdata = flags_host.voltage_a;
    end else if (hit(reg_addr, ADDR_VOLTAGE_B_HOST)) begin
      next_rdata = flags_host.voltage_b;
    end else if (hit(reg_addr, ADDR_FAN_HOST)) begin
      next_rdata = flags_host.fan;
    end else if (hit(reg_addr, ADDR_DIGITAL_HOST)) begin
      next_rdata = flags_host.digital;
    end else if (hit(reg_addr, ADDR_GENERAL_PIN_HOST)) begin
      next_rdata = general_pin_flags_host;
    end else if (hit(reg_addr, ADDR_THERMAL_A_MGMT)) begin
      next_rdata = flags_mgmt.thermal_a;
    end else if (hit(reg_addr, ADDR_THERMAL_B_MGMT)) begin
      next_rdata = flags_mgmt.thermal_b;
    end else if (hit(reg_addr, ADDR_VOLTAGE_A_MGMT)) begin
      next_rdata = flags_mgmt.voltage_a;
    end else if (hit(reg_addr, ADDR_VOLTAGE_B_MGMT)) begin
      next_rdata = flags_mgmt.voltage_b;
    end else if (hit(reg_addr, ADDR_FAN_MGMT)) begin
      next_rdata = flags_mgmt.fan;
    end else if (hit(reg_addr, ADDR_DIGITAL_MGMT)) begin
      next_rdata = flags_mgmt.digital;
    end else begin
      next_rdata = RESET_ZERO;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= RESET_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ===========================================
  // control outputs
  always_comb begin
    ctrl.block_read_len = primary_config[BLOCK_LEN_MSB:0];
    ctrl.table_select = primary_config[TABLE_SEL_BIT];
    ctrl.monitor_enable = monitor_control_config[MONITOR_EN_BIT];
    ctrl.alert_comparator = monitor_control_config[ALERT_MODE_BIT];
    ctrl.skip_fast_spinup = monitor_control_config[SKIP_SPINUP_BIT];
    ctrl.setup_complete = monitor_control_config[SETUP_DONE_BIT];
    ctrl.locked = monitor_control_config[LOCK_BIT];
  end
  assign monitoring_active = monitor_control_config[SETUP_DONE_BIT] &&
                             monitor_control_config[MONITOR_EN_BIT] && ready_q;

  // ===========================================
  // assertions
  a_lock_holds_config: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(monitor_control_config[LOCK_BIT]) |-> $stable(primary_config))
    else $error("primary config changed while locked");
  a_lock_holds_control: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(monitor_control_config[LOCK_BIT]) |-> $stable(monitor_control_config))
    else $error("control register changed while locked");
  a_lock_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    monitor_control_config[LOCK_BIT] |=> monitor_control_config[LOCK_BIT])
    else $error("lock bit cleared");
  a_restore_needs_key: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restore |-> unlock_key == UNLOCK_KEY)
    else $error("restore without key");
  a_key_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, ADDR_UNLOCK_KEY) |=> unlock_key == $past(reg_wdata))
    else $error("key write lost");
  a_key_spent: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restore |=> unlock_key == RESET_ZERO)
    else $error("key survives restore");
  a_restore_values: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restore |=> primary_config == RESET_PRIMARY_CONFIG &&
    monitor_control_config == STORED_CONTROL_RESET)
    else $error("restore did not reload config");
  a_restore_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restore |=> flags_host == '0 && flags_mgmt == '0)
    else $error("flags survive restore");
  a_pin_restore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restore |=> general_pin_flags_host == RESET_ZERO)
    else $error("pin status survives restore");
  a_duty_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restore |=> $stable(fan_drive_duty))
    else $error("duty changed by restore");
  a_reset_bit_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !primary_config[SOFT_RESTORE_BIT])
    else $error("reset bit stuck");
  a_config_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, ADDR_PRIMARY_CONFIG) && !monitor_control_config[LOCK_BIT] &&
    !restore |=> primary_config == {1'b0, $past(reg_wdata[TABLE_SEL_BIT:0])})
    else $error("primary config write lost");
  a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, ADDR_MONITOR_CONTROL) && !monitor_control_config[LOCK_BIT]
    |=> monitor_control_config[SETUP_DONE_BIT:0] == $past(reg_wdata[SETUP_DONE_BIT:0]))
    else $error("control write lost");
  a_ready_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    power_good ##1 power_good |-> ready_q)
    else $error("ready not set");
  a_ready_drops: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !power_good ##1 !power_good |-> !ready_q)
    else $error("ready not cleared");
  a_read_control: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, ADDR_MONITOR_CONTROL) |=>
    reg_rdata == {$past(ready_q), $past(monitor_control_config[LOCK_BIT:0])})
    else $error("control read wrong");
  a_read_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after request");
  a_drive_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, ADDR_DRIVE1) |=> fan_drive_duty[7:0] == $past(reg_wdata))
    else $error("duty write lost");
  a_pin_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    general_pin_set_host && !restore |=> general_pin_flags_host == $past(general_pin_in))
    else $error("pin status not loaded");
  a_monitor_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
    monitoring_active |-> ctrl.setup_complete && ctrl.monitor_enable)
    else $error("monitoring without setup");
  a_flag_copies: assert property (@(posedge ref_clk) disable iff (!rst_n)
    |flag_set.fan && !restore |=> (flags_host.fan & flags_mgmt.fan) != RESET_ZERO)
    else $error("flag not in both copies");
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    flags_mgmt.fan != RESET_ZERO && !restore && !(reg_rd && hit(reg_addr, ADDR_FAN_MGMT))
    |=> flags_mgmt.fan != RESET_ZERO)
    else $error("flag lost without read");
  c_restore: cover property (@(posedge ref_clk) disable iff (!rst_n) restore);
  c_lock: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(monitor_control_config[LOCK_BIT]));
  c_monitor: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(monitoring_active));
  c_locked_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    monitor_control_config[LOCK_BIT] && reg_wr && hit(reg_addr, ADDR_PRIMARY_CONFIG));
  c_flag_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, ADDR_FAN_HOST) && flags_host.fan != RESET_ZERO);
endmodule

// >>> tb/mcsr_host_model.sv
// host-side model of the serial engine that issues register requests
`timescale 1ns/1ps
module mcsr_host_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  import mcsr_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // ===========================================
  // transfers; released lines show the inverse of the last value
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
    #1;
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    #1;
    valid = reg_rvalid;
    data = reg_rdata;
  endtask
  // key first, then the restore bit
  task automatic keyed_restore(input logic [7:0] cfg);
    write_reg(ADDR_UNLOCK_KEY, UNLOCK_KEY);
    write_reg(ADDR_PRIMARY_CONFIG, cfg | 8'h80);
  endtask
endmodule

// >>> tb/mcsr_regs_bench.sv
// self-checking bench of the configuration and status register bank
`timescale 1ns/1ps
module mcsr_regs_bench;
  import mcsr_pkg::*;
  logic ref_clk, rst_n, reg_wr, reg_rd, rvalid, pin_set, power_good, restore_pulse, active;
  logic [7:0] addr, wdata, rdata, pin_in;
  logic [31:0] duty;
  mcsr_meas_type meas;
  mcsr_flags_type flag_set;
  mcsr_ctrl_type ctrl;
  int fails, check_count, pulses;
  // ===========================================
  // design and host
  mcsr_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .meas(meas), .flag_set(flag_set), .general_pin_set_host(pin_set),
    .general_pin_in(pin_in), .power_good(power_good), .ctrl(ctrl),
    .monitoring_active(active), .fan_drive_duty(duty), .soft_restore_pulse(restore_pulse));
  mcsr_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (restore_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  // ===========================================
  // helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.read_reg(a, d, v);
    check({name, " valid"}, v, 1'b1);
    check(name, d, exp);
  endtask
  task automatic pulse_flags(input mcsr_flags_type v);
    @(posedge ref_clk);
    flag_set <= v;
    @(posedge ref_clk);
    flag_set <= '0;
  endtask
  task automatic final_report();
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ===========================================
  // scenarios
  task automatic test_reset_values();
    logic [7:0] amap [7] = '{8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hAE, 8'hAF};
    logic [55:0] m;
    m = meas;
    rd_check("primary", ADDR_PRIMARY_CONFIG, 8'h20);
    rd_check("control", ADDR_MONITOR_CONTROL, 8'h81);
    check("block len", ctrl.block_read_len, 6'h20);
    check("table", ctrl.table_select, 1'b0);
    check("mon en", ctrl.monitor_enable, 1'b1);
    check("alert", ctrl.alert_comparator, 1'b0);
    check("skip", ctrl.skip_fast_spinup, 1'b0);
    check("setup", ctrl.setup_complete, 1'b0);
    check("locked", ctrl.locked, 1'b0);
    check("active", active, 1'b0);
    check("duty", duty, 32'h00C00000);
    rd_check("duty3", 8'hAC, 8'hC0);
    for (int i = 0; i < 7; i++) begin
      rd_check("meas", amap[i], m[55-8*i -: 8]);
    end
    rd_check("unmapped", 8'h50, 8'h00);
  endtask
  task automatic test_config_fields();
    host.write_reg(ADDR_PRIMARY_CONFIG, 8'h5F);
    host.write_reg(ADDR_MONITOR_CONTROL, 8'h38);
    check("block len", ctrl.block_read_len, 6'h1F);
    check("table", ctrl.table_select, 1'b1);
    check("mon en", ctrl.monitor_enable, 1'b0);
    check("alert", ctrl.alert_comparator, 1'b1);
    check("skip", ctrl.skip_fast_spinup, 1'b1);
    check("setup", ctrl.setup_complete, 1'b1);
    check("active", active, 1'b0);
    rd_check("control", ADDR_MONITOR_CONTROL, 8'hB8);
    host.write_reg(ADDR_MONITOR_CONTROL, 8'h21);
    check("active", active, 1'b1);
    @(posedge ref_clk);
    power_good <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_check("not ready", ADDR_MONITOR_CONTROL, 8'h21);
    check("active", active, 1'b0);
    @(posedge ref_clk);
    power_good <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic test_restore();
    host.write_reg(ADDR_DRIVE1, 8'h5A);
    pulse_flags(56'h80_00_00_00_00_00_00);
    host.write_reg(ADDR_PRIMARY_CONFIG, 8'hDF);
    check("no key", pulses, 0);
    rd_check("no key", ADDR_PRIMARY_CONFIG, 8'h5F);
    host.keyed_restore(8'h00);
    check("restore", pulses, 1);
    check("restore setup", ctrl.setup_complete, 1'b0);
    rd_check("primary", ADDR_PRIMARY_CONFIG, 8'h20);
    rd_check("control", ADDR_MONITOR_CONTROL, 8'h81);
    rd_check("host flags", ADDR_THERMAL_A_HOST, 8'h00);
    rd_check("mgmt flags", ADDR_THERMAL_A_MGMT, 8'h00);
    check("duty kept", duty[7:0], 8'h5A);
    rd_check("key", ADDR_UNLOCK_KEY, 8'h00);
    host.write_reg(ADDR_PRIMARY_CONFIG, 8'hA0);
    check("key spent", pulses, 1);
  endtask
  task automatic test_flags();
    logic [7:0] ha [7] = '{8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE};
    logic [7:0] ma [7] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6};
    logic [55:0] v;
    v = 56'h81_42_24_18_F0_A5_C8;
    pulse_flags(v);
    for (int i = 0; i < 7; i++) begin
      rd_check("host copy", ha[i], v[55-8*i -: 8]);
      rd_check("mgmt copy", ma[i], (i == 2) ? 8'h00 : v[55-8*i -: 8]);
      rd_check("cleared", ha[i], 8'h00);
    end
    @(posedge ref_clk);
    pin_in <= 8'h96;
    pin_set <= 1'b1;
    @(posedge ref_clk);
    pin_set <= 1'b0;
    rd_check("pins", ADDR_GENERAL_PIN_HOST, 8'h96);
    host.write_reg(ADDR_GENERAL_PIN_HOST, 8'h3C);
    rd_check("pins", ADDR_GENERAL_PIN_HOST, 8'h3C);
  endtask
  task automatic test_lock();
    host.write_reg(ADDR_MONITOR_CONTROL, 8'h61);
    check("locked", ctrl.locked, 1'b1);
    host.write_reg(ADDR_PRIMARY_CONFIG, 8'h4A);
    rd_check("locked primary", ADDR_PRIMARY_CONFIG, 8'h20);
    host.write_reg(ADDR_MONITOR_CONTROL, 8'h00);
    rd_check("locked control", ADDR_MONITOR_CONTROL, 8'hE1);
    host.keyed_restore(8'h00);
    check("locked restore", pulses, 1);
    check("still active", active, 1'b1);
    host.write_reg(ADDR_DRIVE1, 8'h33);
    check("duty", duty[7:0], 8'h33);
  endtask
  // ===========================================
  // main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    pin_set = 1'b0;
    pin_in = 8'h00;
    power_good = 1'b1;
    flag_set = '0;
    meas = 56'h11_22_33_44_55_66_77;
    fails = 0;
    check_count = 0;
    pulses = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_config_fields();
    test_restore();
    test_flags();
    test_lock();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    final_report();
  end
endmodule
